// [adc_serial_pkg.sv]
// Shared constants and types of the dual converter serial and power logic.
// Assumes one 100 MHz clock that samples the host's select and serial clock.
package adc_serial_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int RES_BITS = 12;
    localparam int FRAME_BITS = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 6;

    // ------------------------------------------------------------------
    // Falling-edge counts that mark positions in a frame
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_GLITCH = 6'h02;
    localparam logic [CNT_W-1:0] CNT_PDN_END = 6'h0A;
    localparam logic [CNT_W-1:0] CNT_TRACK = 6'h0D;
    localparam logic [CNT_W-1:0] CNT_DONE = 6'h0E;
    localparam logic [CNT_W-1:0] CNT_END = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

    // ------------------------------------------------------------------
    // Types and reset values
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_PARTIAL = 2'b01,
        PWR_FULL = 2'b10
    } pwr_state_t;

    typedef struct packed {
        logic [RES_BITS-1:0] a;
        logic [RES_BITS-1:0] b;
    } result_pair_t;

    localparam pwr_state_t PWR_RESET = PWR_NORMAL;
    localparam logic CS_IDLE = 1'b1;
    localparam logic SCLK_IDLE = 1'b0;

endpackage : adc_serial_pkg

// [sync_two_ff.sv]
// Two flip-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clock; only the second stage is read.
`timescale 1ns/1ps
module sync_two_ff #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pin and synchronised level
    input wire logic din,
    output logic q
);
    logic meta_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= din;
            q <= meta_r;
        end
    end

endmodule : sync_two_ff

// [result_fifo.sv]
// Result FIFO between the converter cores and the serial shifter.
// Assumes DEPTH is a power of two; both sides run on clock.
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != CW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r <= count_r + CW'(push) - CW'(pop);
        end
    end

endmodule : result_fifo

// [dual_adc_serial_power_ctrl.sv]
// Serial readout and power sequencing of a dual sampling converter.
// Assumes results arrive as pairs on clock; select and serial clock are pins.
//
// Function
// - Select rise between falls 2 and 9: normal to partial, partial to full.
// - Full power-down switches off analog circuits and the reference too.
// - The early select rise alone powers down; no full frame needed.
// - Wake-up starts at select fall of a frame held past fall ten.
// - Select fall holds the sample, starts conversion, enables both lines.
// - After 13 counted falls, the next rise returns to track.
// - A 16-clock frame shows two zeros after the last result bit.
// - Any select rise aborts conversion and releases both data lines.
// - A longer frame chains the other channel's result on each line.
// - In a chained read the line releases at fall 32 or select rise.
// - Two leading zeros, then 12 bits MSB first, one per fall.
// - A fall coincident with select fall, and early rises, are ignored.
// - Select rise after fall ten keeps power but aborts the frame.
// - Select rise before fall two in normal mode is a glitch.
// - While waking, a rise before fall ten powers down again.
`timescale 1ns/1ps
module dual_adc_serial_power_ctrl
    import adc_serial_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host serial pins
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    // Conversion results from the converter cores
    input wire logic conv_valid,
    input wire result_pair_t conv_data,
    output logic conv_ready,
    // Data lines, enable high while driving
    output logic data_out_a,
    output logic data_oe_a,
    output logic data_out_b,
    output logic data_oe_b,
    // Analog control
    output logic track_hold,
    output logic conv_active,
    output logic analog_on,
    output logic reference_on,
    output pwr_state_t power_state
);
    // ------------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------------
    logic cs_n_s;
    logic sclk_s;
    logic cs_n_d_r;
    logic sclk_d_r;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic fall_cnt;

    sync_two_ff #(.INIT(CS_IDLE)) u_sync_cs (
        .clock(clock),
        .rst(rst),
        .din(cs_n_pin),
        .q(cs_n_s)
    );

    sync_two_ff #(.INIT(SCLK_IDLE)) u_sync_sclk (
        .clock(clock),
        .rst(rst),
        .din(sclk_pin),
        .q(sclk_s)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_n_d_r <= CS_IDLE;
            sclk_d_r <= SCLK_IDLE;
        end else begin
            cs_n_d_r <= cs_n_s;
            sclk_d_r <= sclk_s;
        end
    end

    logic in_frame_r;

    assign cs_fall = cs_n_d_r & ~cs_n_s;
    assign cs_rise = ~cs_n_d_r & cs_n_s;
    // A fall in the select-fall cycle finds in_frame_r still low.
    assign fall_cnt = sclk_d_r & ~sclk_s & in_frame_r & ~cs_n_s;
    assign sclk_rise = ~sclk_d_r & sclk_s & in_frame_r & ~cs_n_s;

    // ------------------------------------------------------------------
    // Result FIFO
    // ------------------------------------------------------------------
    // Back-pressure reaches the cores: a frame pops one pair only.
    logic fifo_valid;
    result_pair_t fifo_data;
    result_pair_t pair;

    result_fifo #(.WIDTH($bits(result_pair_t)), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(conv_valid),
        .in_data(conv_data),
        .in_ready(conv_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(cs_fall)
    );

    // An empty FIFO yields a zero result rather than stale data.
    assign pair = fifo_valid ? fifo_data : '0;

    // ------------------------------------------------------------------
    // Frame counter and shifters
    // ------------------------------------------------------------------
    function automatic logic [FRAME_BITS-1:0] frame_word(
        input logic [RES_BITS-1:0] first,
        input logic [RES_BITS-1:0] second
    );
        frame_word = {2'b00, first, 4'h0, second, 2'b00};
    endfunction : frame_word

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_inc;
    logic [FRAME_BITS-1:0] sh_a_r;
    logic [FRAME_BITS-1:0] sh_b_r;
    logic oe_r;

    assign cnt_inc = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 6'h01;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (cs_n_s || cs_fall) begin
            cnt_r <= '0;
        end else if (fall_cnt) begin
            cnt_r <= cnt_inc;
        end
    end

    // Line A sends A then B, line B sends B then A.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sh_a_r <= '0;
            sh_b_r <= '0;
        end else if (cs_fall) begin
            sh_a_r <= frame_word(pair.a, pair.b);
            sh_b_r <= frame_word(pair.b, pair.a);
        end else if (fall_cnt) begin
            sh_a_r <= {sh_a_r[FRAME_BITS-2:0], 1'b0};
            sh_b_r <= {sh_b_r[FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else if (cs_fall) begin
            oe_r <= 1'b1;
        end else if (cs_rise) begin
            oe_r <= 1'b0;
        end else if (fall_cnt && cnt_inc == CNT_END) begin
            oe_r <= 1'b0;
        end
    end

    assign data_out_a = sh_a_r[FRAME_BITS-1];
    assign data_out_b = sh_b_r[FRAME_BITS-1];
    assign data_oe_a = oe_r;
    assign data_oe_b = oe_r;

    // ------------------------------------------------------------------
    // Track-and-hold and conversion
    // ------------------------------------------------------------------
    logic hold_r;
    logic active_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_r <= 1'b0;
        end else if (cs_fall) begin
            hold_r <= 1'b1;
        end else if (cs_rise) begin
            hold_r <= 1'b0;
        end else if (sclk_rise && cnt_r >= CNT_TRACK) begin
            hold_r <= 1'b0;
        end
    end

    // The serial clock paces the conversion; fall 14 completes it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
        end else if (cs_fall) begin
            active_r <= 1'b1;
        end else if (cs_rise) begin
            active_r <= 1'b0;
        end else if (fall_cnt && cnt_inc == CNT_DONE) begin
            active_r <= 1'b0;
        end
    end

    assign track_hold = hold_r;
    assign conv_active = active_r;

    // ------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------
    // Only the select rise moves the state, so no full frame is needed.
    pwr_state_t pwr_r;
    pwr_state_t pwr_cut;
    pwr_state_t pwr_nxt;
    logic frame_nxt;
    logic analog_r;
    logic ref_r;

    assign pwr_cut = (pwr_r == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL;
    assign pwr_nxt = !cs_rise ? pwr_r :
                     (cnt_r >= CNT_PDN_END) ? PWR_NORMAL :
                     (cnt_r >= CNT_GLITCH) ? pwr_cut :
                     pwr_r;
    assign frame_nxt = cs_fall | (in_frame_r & ~cs_rise);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwr_r <= PWR_RESET;
            in_frame_r <= 1'b0;
            analog_r <= 1'b1;
            ref_r <= 1'b1;
        end else begin
            pwr_r <= pwr_nxt;
            in_frame_r <= frame_nxt;
            // Power-up begins at the frame's select fall.
            analog_r <= (pwr_nxt == PWR_NORMAL) | frame_nxt;
            ref_r <= (pwr_nxt != PWR_FULL) | frame_nxt;
        end
    end

    assign analog_on = analog_r;
    assign reference_on = ref_r;
    assign power_state = pwr_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_cut_rise;
        cs_rise && cnt_r >= CNT_GLITCH && cnt_r < CNT_PDN_END;
    endsequence

    // The rise must still see count 13, so a rise of a later frame or
    // one after fall 14 cannot complete the sequence.
    sequence s_thirteenth;
        fall_cnt && cnt_inc == CNT_TRACK ##[1:40]
            (sclk_rise && cnt_r == CNT_TRACK);
    endsequence

    property p_partial_entry;
        s_cut_rise and pwr_r == PWR_NORMAL |=> pwr_r == PWR_PARTIAL;
    endproperty
    a_partial_entry: assert property (p_partial_entry)
        else $error("cut frame did not enter partial power-down");

    property p_full_entry;
        s_cut_rise and pwr_r == PWR_PARTIAL |=> pwr_r == PWR_FULL;
    endproperty
    a_full_entry: assert property (p_full_entry)
        else $error("second cut frame did not enter full power-down");

    property p_full_off;
        pwr_r == PWR_FULL && !in_frame_r |-> !analog_r && !ref_r;
    endproperty
    a_full_off: assert property (p_full_off)
        else $error("analog or reference on in full power-down");

    property p_wake_start;
        cs_fall |=> analog_r && ref_r && in_frame_r;
    endproperty
    a_wake_start: assert property (p_wake_start)
        else $error("power-up did not start at select fall");

    property p_frame_start;
        cs_fall |=> hold_r && oe_r && active_r && !data_out_a && !data_out_b;
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("select fall did not start the frame");

    property p_track_return;
        s_thirteenth |=> !hold_r;
    endproperty
    a_track_return: assert property (p_track_return)
        else $error("track mode not resumed after fall 13");

    property p_trailing_zeros;
        fall_cnt && cnt_r == CNT_TRACK |=> !data_out_a && !data_out_b;
    endproperty
    a_trailing_zeros: assert property (p_trailing_zeros)
        else $error("trailing zero missing after the last bit");

    property p_abort;
        cs_rise |=> !oe_r && !active_r && !hold_r;
    endproperty
    a_abort: assert property (p_abort)
        else $error("select rise did not abort the frame");

    property p_release_32;
        fall_cnt && cnt_inc == CNT_END |=> !oe_r;
    endproperty
    a_release_32: assert property (p_release_32)
        else $error("line not released at fall 32");

    property p_stay_up;
        cs_rise && cnt_r >= CNT_PDN_END |=> pwr_r == PWR_NORMAL && analog_r;
    endproperty
    a_stay_up: assert property (p_stay_up)
        else $error("long frame did not leave the device powered");

    property p_glitch;
        cs_rise && cnt_r < CNT_GLITCH |=> pwr_r == $past(pwr_r);
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("select glitch changed the power state");

    property p_count_clear;
        cs_n_s || cs_fall |=> cnt_r == '0;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("fall counter not cleared while select high");

endmodule : dual_adc_serial_power_ctrl

// [host_serial_model.sv]
// Host serial port model: drives select and serial clock, samples the lines.
// Assumes it is called at a falling clock edge; all delays are 10 ns steps.
`timescale 1ns/1ps
module host_serial_model (
    // Clock of the bench
    input wire logic clock,
    // Pins towards the device
    output logic cs_n_pin,
    output logic sclk_pin,
    // Lines and state seen from the device
    input wire logic data_out_a,
    input wire logic data_out_b,
    input wire logic data_oe_a,
    input wire logic track_hold
);
    // ------------------------------------------------------------------
    // Captures of one frame: lines indexed by counted falls, hold by rises
    // ------------------------------------------------------------------
    logic cap_a [0:32];
    logic cap_b [0:32];
    logic cap_oe [0:32];
    logic cap_th [0:32];

    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
    end

    // ------------------------------------------------------------------
    // One frame of nf falls at 80 ns; the serial clock stands low between.
    // ------------------------------------------------------------------
    task automatic run_frame(input int nf, input bit coinc);
        @(negedge clock);
        if (coinc) begin
            sclk_pin = 1'b1;
            #40;
        end
        cs_n_pin = 1'b0;
        sclk_pin = 1'b0;
        #80;
        cap_th[0] = track_hold;
        for (int k = 1; k <= nf; k++) begin
            // Taken just before each rise, as a rising-edge host would.
            cap_a[k-1] = data_out_a;
            cap_b[k-1] = data_out_b;
            cap_oe[k-1] = data_oe_a;
            sclk_pin = 1'b1;
            #40;
            cap_th[k] = track_hold;
            sclk_pin = 1'b0;
            #40;
        end
        cap_a[nf] = data_out_a;
        cap_b[nf] = data_out_b;
        cap_oe[nf] = data_oe_a;
        // The select rise alone ends the frame, after the nf falls sent.
        cs_n_pin = 1'b1;
        // No wake time is modelled, so this idle stands for both waits.
        #80;
    endtask : run_frame
endmodule : host_serial_model

// [dual_adc_serial_power_ctrl_tb_top.sv]
// Self-checking bench of the dual converter serial and power logic.
// Assumes the host model above and a 16-deep result buffer in the design.
`timescale 1ns/1ps
module dual_adc_serial_power_ctrl_tb_top import adc_serial_pkg::*;;
    logic clock;
    logic rst;
    logic conv_valid;
    logic conv_ready;
    result_pair_t conv_data;
    logic cs_n_pin;
    logic sclk_pin;
    logic data_out_a;
    logic data_oe_a;
    logic data_out_b;
    logic data_oe_b;
    logic track_hold;
    logic conv_active;
    logic analog_on;
    logic reference_on;
    pwr_state_t power_state;
    pwr_state_t pst;
    int n_mismatch;
    int compares;
    result_pair_t exp_q[$];
    int plan [12] = '{32, 16, 14, 1, 5, 1, 9, 12, 2, 10, 13, 32};

    dual_adc_serial_power_ctrl #(.DEPTH(FIFO_DEPTH)) uut (
        .clock(clock), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .conv_valid(conv_valid), .conv_data(conv_data),
        .conv_ready(conv_ready), .data_out_a(data_out_a),
        .data_oe_a(data_oe_a), .data_out_b(data_out_b),
        .data_oe_b(data_oe_b), .track_hold(track_hold),
        .conv_active(conv_active), .analog_on(analog_on),
        .reference_on(reference_on), .power_state(power_state));

    host_serial_model host (
        .clock(clock), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .data_out_a(data_out_a), .data_out_b(data_out_b),
        .data_oe_a(data_oe_a), .track_hold(track_hold));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen,
                     exp);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    function automatic logic [31:0] word_of(result_pair_t p, bit on_b);
        return on_b ? {2'b00, p.b, 4'h0, p.a, 2'b00}
                    : {2'b00, p.a, 4'h0, p.b, 2'b00};
    endfunction : word_of

    function automatic pwr_state_t next_pwr(pwr_state_t s, int nf);
        if (nf < 2) return s;
        if (nf >= 10) return PWR_NORMAL;
        return (s == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL;
    endfunction : next_pwr

    // ------------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------------
    task automatic push(input result_pair_t p);
        int w = 0;
        @(negedge clock);
        conv_valid = 1'b1;
        conv_data = p;
        while (conv_ready !== 1'b1 && w < 100) begin
            @(negedge clock);
            w++;
        end
        if (w == 100) begin
            check(1'b0, 1'b1, "push wait ran out");
            complete_run();
        end
        @(negedge clock);
        conv_valid = 1'b0;
        exp_q.push_back(p);
    endtask : push

    task automatic frame(input int nf, input bit coinc);
        result_pair_t p;
        logic [31:0] wa;
        logic [31:0] wb;
        p = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
        wa = word_of(p, 1'b0);
        wb = word_of(p, 1'b1);
        host.run_frame(nf, coinc);
        for (int k = 0; k <= nf; k++) begin
            check(host.cap_oe[k], k < 32, "line enable");
            check(host.cap_th[k], k <= 13, "hold");
            if (k < 32) begin
                check(host.cap_a[k], wa[31-k], "line a");
                check(host.cap_b[k], wb[31-k], "line b");
            end
        end
        pst = next_pwr(pst, nf);
        check(power_state, pst, "power");
        check({data_oe_a, data_oe_b, track_hold, conv_active}, 0,
              "abort");
        check(analog_on, pst == PWR_NORMAL, "analog");
        check(reference_on, pst != PWR_FULL, "reference");
        $display("frame test of %0d falls done", nf);
    endtask : frame

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #200000;
        check(1'b0, 1'b1, "run limit reached");
        complete_run();
    end

    initial begin
        int nf;
        rst = 1'b1;
        conv_valid = 1'b0;
        conv_data = '0;
        n_mismatch = 0;
        compares = 0;
        pst = PWR_RESET;
        void'($urandom(32'h92C6));
        repeat (4) @(posedge clock);
        check(power_state, PWR_RESET, "reset power");
        check({data_oe_a, data_oe_b, track_hold, conv_ready}, 4'h1, "reset");
        @(negedge clock);
        rst = 1'b0;
        $display("reset test done");
        // Extreme codes first: full scale and zero, then MSB only on A and LSB only on B.
        push(24'hFFF000);
        push(24'h800001);
        for (int i = 2; i < FIFO_DEPTH; i++) begin
            push(result_pair_t'(24'($urandom)));
        end
        // A full buffer refuses; the host has not popped anything yet.
        @(negedge clock);
        conv_valid = 1'b1;
        conv_data = 24'hABCDEF;
        repeat (3) @(negedge clock);
        check(conv_ready, 1'b0, "buffer full");
        conv_valid = 1'b0;
        $display("fill test done");
        for (int i = 0; i < 12; i++) begin
            frame(plan[i], i == 11);
        end
        frame(3, 1'b0);
        frame(3, 1'b0);
        for (int i = 0; i < 20; i++) begin
            nf = 1 + ($urandom % 32);
            frame(nf, 1'($urandom % 2));
        end
        complete_run();
    end
endmodule : dual_adc_serial_power_ctrl_tb_top
